// *** design/otc_pkg.sv ***
// package: field layouts, codes, reset values and burst lengths for termination control
package otc_pkg;
  localparam int OTC_FIELD_W = 3;
  localparam int OTC_CFG_W = 8;
  localparam int OTC_OVR_W = 8;
  // termination configuration register layout
  localparam int OTC_DQ_LSB = 0;
  localparam int OTC_CA_LSB = 4;
  // override register bit positions
  localparam int OTC_CK_DIS_BIT = 3;
  localparam int OTC_CS_DIS_BIT = 4;
  localparam int OTC_CA_DIS_BIT = 5;
  // field codes
  localparam logic [2:0] OTC_CODE_OFF = 3'h0;
  localparam logic [2:0] OTC_CODE_MAX = 3'h6;
  localparam logic [2:0] OTC_CODE_BAD = 3'h7;
  // reference resistance in ohms
  localparam logic [7:0] OTC_RREF_OHM = 8'hF0;
  // reset values of both set-point copies
  localparam logic [7:0] OTC_CFG_RST = 8'h00;
  localparam logic [7:0] OTC_OVR_RST = 8'h00;
  localparam int OTC_BL_W = 6;
  localparam logic [5:0] OTC_BL16 = 6'h10;
  localparam logic [5:0] OTC_BL32 = 6'h20;
  typedef enum logic [1:0] {
    OTC_DQ_IDLE = 2'b00,
    OTC_DQ_WAIT = 2'b01,
    OTC_DQ_ON = 2'b10
  } otc_dq_e;
endpackage

// *** design/otc_rdecode.sv ***
// resistance decoder: field code to ohms, zero when off or unused
`timescale 1ns/1ps
module otc_rdecode (
  input wire logic i_mclk, // command clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [otc_pkg::OTC_FIELD_W-1:0] i_code, // termination field code
  output logic [7:0] o_ohm, // registered resistance in ohms
  output logic o_valid // registered code in 001b..110b
);
  import otc_pkg::*;
  typedef struct packed {
    logic [7:0] ohm;
    logic valid;
  } otc_dec_s;
  otc_dec_s st;
  otc_dec_s next_st;

  // reference divided by code; 000b and 111b give no termination
  always_comb begin
    next_st = st;
    next_st.valid = (i_code != OTC_CODE_OFF) && (i_code <= OTC_CODE_MAX);
    if (next_st.valid) begin
      next_st.ohm = OTC_RREF_OHM / {5'h00, i_code};
    end else begin
      next_st.ohm = 8'h00;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ohm = st.ohm;
  assign o_valid = st.valid;
endmodule

// *** design/otc_term_ctrl.sv ***
// on-die termination control for command bus and data bus
`timescale 1ns/1ps
module otc_term_ctrl #(
  parameter int DQ_LINES = 16, // data lines per channel
  parameter int DMI_LINES = 2, // mask/inversion lines
  parameter int DQS_LINES = 2, // strobe pairs
  parameter logic [5:0] ODTL_ON = 6'h04, // write to termination-on latency, cycles
  parameter logic [5:0] ODTL_OFF = 6'h14 // write to termination-off latency at BL16, cycles
) (
  input wire logic i_mclk, // command clock, 40 MHz
  input wire logic i_rst_b, // sync reset, active low
  input wire logic i_mrw_cfg, // pulse: write termination_config_reg
  input wire logic i_mrw_ovr, // pulse: write termination_override_reg
  input wire logic [7:0] i_mrw_data, // mode-register write data
  input wire logic i_fsp_wr, // set point copy addressed by writes
  input wire logic i_active_freq_set_point, // active_freq_set_point
  input wire logic i_wr_first, // pulse: first part of write or masked write
  input wire logic i_bl32, // burst of this write is 32
  input wire logic i_power_down, // power-down state
  input wire logic i_self_refresh, // self-refresh with clock-enable low
  input wire logic i_wr_level, // write leveling mode
  output logic [7:0] o_cfg_rd, // termination_config_reg of write set point
  output logic [7:0] o_ovr_rd, // termination_override_reg of write set point
  output logic [7:0] o_ca_ohm, // command-bus term_resistance
  output logic o_ca_term_on, // CA line termination on
  output logic o_ck_term_on, // clock termination on
  output logic o_cs_term_on, // chip-select termination on
  output logic [7:0] o_dq_ohm, // data-bus term_resistance
  output logic [DQ_LINES-1:0] o_dq_term_on, // per data line termination
  output logic [DMI_LINES-1:0] o_dmi_term_on, // per data_mask_invert_line termination
  output logic [DQS_LINES-1:0] o_dqs_term_on // per strobe termination
);
  import otc_pkg::*;

  // refuse parameters that the line switches or the window counter cannot serve
  if (DQ_LINES < 1) begin : g_bad_dq
    $error("otc_term_ctrl: DQ_LINES must be at least one");
  end
  if (DMI_LINES < 1) begin : g_bad_dmi
    $error("otc_term_ctrl: DMI_LINES must be at least one");
  end
  if (DQS_LINES < 1) begin : g_bad_dqs
    $error("otc_term_ctrl: DQS_LINES must be at least one");
  end
  if (ODTL_ON == 6'h00) begin : g_bad_on
    $error("otc_term_ctrl: ODTL_ON must be nonzero");
  end
  if (ODTL_OFF <= ODTL_ON) begin : g_bad_off
    $error("otc_term_ctrl: ODTL_OFF must exceed ODTL_ON");
  end

  // latencies widened to the window counter
  localparam logic [6:0] ON_LAT = {1'b0, ODTL_ON};
  localparam logic [6:0] OFF_LAT = {1'b0, ODTL_OFF};
  localparam logic [6:0] BL32_EXTRA = {1'b0, (OTC_BL32 - OTC_BL16) >> 1}; // half the extra beats

  typedef struct packed {
    logic [1:0][7:0] cfg;
    logic [1:0][7:0] ovr;
    otc_dq_e dq_st;
    logic [6:0] cnt;
    logic [6:0] off_at;
    logic ca_on;
    logic ck_on;
    logic cs_on;
    logic dq_on;
    logic dqs_on;
    logic [7:0] cfg_rd;
    logic [7:0] ovr_rd;
  } otc_st_s;
  otc_st_s st;
  otc_st_s next_st;

  logic [2:0] ca_code;
  logic [2:0] dq_code;
  logic [7:0] act_cfg;
  logic [7:0] act_ovr;
  logic ca_valid;
  logic dq_valid;
  logic dq_block;
  logic [6:0] wr_off;

  // active copies chosen by operating set point
  assign act_cfg = st.cfg[i_active_freq_set_point];
  assign act_ovr = st.ovr[i_active_freq_set_point];

  // field codes of the active copy
  assign ca_code = act_cfg[OTC_CA_LSB +: OTC_FIELD_W];
  assign dq_code = act_cfg[OTC_DQ_LSB +: OTC_FIELD_W];

  // power-down and self-refresh keep the data bus unterminated
  assign dq_block = i_power_down | i_self_refresh;

  // off point of a write, later for a 32-beat burst
  assign wr_off = OFF_LAT + (i_bl32 ? BL32_EXTRA : 7'h00);

  // resistance decoders, one per bus
  otc_rdecode u_ca_dec (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_code(ca_code),
    .o_ohm(o_ca_ohm),
    .o_valid(ca_valid)
  );
  otc_rdecode u_dq_dec (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_code(dq_code),
    .o_ohm(o_dq_ohm),
    .o_valid(dq_valid)
  );

  // next-state logic: register writes, bus states, write window
  always_comb begin
    next_st = st;
    if (i_mrw_cfg) begin
      next_st.cfg[i_fsp_wr] = i_mrw_data;
    end
    if (i_mrw_ovr) begin
      next_st.ovr[i_fsp_wr] = i_mrw_data;
    end
    // read-back of the addressed copy, aligned with the decoder outputs
    next_st.cfg_rd = st.cfg[i_fsp_wr];
    next_st.ovr_rd = st.ovr[i_fsp_wr];
    // command bus purely from register contents
    next_st.ca_on = ca_valid & ~act_ovr[OTC_CA_DIS_BIT];
    next_st.ck_on = ca_valid & ~act_ovr[OTC_CK_DIS_BIT];
    next_st.cs_on = ca_valid & ~act_ovr[OTC_CS_DIS_BIT];
    // write window sequencing
    case (st.dq_st)
      // idle: a write opens a window only with the data field enabled
      OTC_DQ_IDLE: begin
        next_st.cnt = 7'h00;
        if (i_wr_first && dq_valid && !i_wr_level) begin
          next_st.dq_st = OTC_DQ_WAIT;
          next_st.cnt = 7'h01;
          next_st.off_at = wr_off;
        end
      end
      // wait: count out the turn-on latency
      OTC_DQ_WAIT: begin
        next_st.cnt = st.cnt + 7'h01;
        if (st.cnt >= ON_LAT) begin
          next_st.dq_st = OTC_DQ_ON;
        end
      end
      // on: a later write restarts the count, so long write streams cannot wrap it
      OTC_DQ_ON: begin
        next_st.cnt = st.cnt + 7'h01;
        if (i_wr_first) begin
          next_st.cnt = 7'h01; // back-to-back writes extend the window
          next_st.off_at = wr_off;
        end else if (st.cnt >= st.off_at) begin
          next_st.dq_st = OTC_DQ_IDLE;
        end
      end
      default: begin
        next_st.dq_st = OTC_DQ_IDLE;
      end
    endcase
    // blocking states and a disabled field end any window
    if (dq_block || !dq_valid) begin
      next_st.dq_st = OTC_DQ_IDLE;
    end
    // data and mask follow the window; strobes also terminate in leveling
    next_st.dq_on = (next_st.dq_st == OTC_DQ_ON) & dq_valid & ~dq_block & ~i_wr_level;
    next_st.dqs_on = dq_valid & ~dq_block & ((next_st.dq_st == OTC_DQ_ON) | i_wr_level);
  end

  // state register; both copies reset to disabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st <= '0;
      st.cfg <= {OTC_CFG_RST, OTC_CFG_RST};
      st.ovr <= {OTC_OVR_RST, OTC_OVR_RST};
      st.dq_st <= OTC_DQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign o_cfg_rd = st.cfg_rd;
  assign o_ovr_rd = st.ovr_rd;
  assign o_ca_term_on = st.ca_on;
  assign o_ck_term_on = st.ck_on;
  assign o_cs_term_on = st.cs_on;

  // per-line switches, one per data, mask and strobe line
  genvar g;
  generate
    // data lines
    for (g = 0; g < DQ_LINES; g++) begin : g_dq
      assign o_dq_term_on[g] = st.dq_on;
    end

    // mask/inversion lines share the data window
    for (g = 0; g < DMI_LINES; g++) begin : g_dmi
      assign o_dmi_term_on[g] = st.dq_on;
    end

    // strobes, also terminated during leveling
    for (g = 0; g < DQS_LINES; g++) begin : g_dqs
      assign o_dqs_term_on[g] = st.dqs_on;
    end
  endgenerate
endmodule

// *** tb/otc_chk_assertions.sv ***
// checker: port properties of termination control
`timescale 1ns/1ps
module otc_chk #(
  parameter logic [5:0] ODTL_OFF = 6'h14 // off latency
) (
  input wire logic i_mclk, // clock
  input wire logic i_rst_b, // reset
  input wire logic i_fsp_wr, // write copy
  input wire logic i_active_freq_set_point, // live copy
  input wire logic i_wr_first, // write
  input wire logic i_power_down, // pd
  input wire logic i_self_refresh, // sr
  input wire logic i_wr_level, // leveling
  input wire logic [7:0] o_cfg_rd, // config
  input wire logic [7:0] o_ovr_rd, // override
  input wire logic [7:0] o_ca_ohm, // ca ohms
  input wire logic [7:0] o_dq_ohm, // dq ohms
  input wire logic o_ca_term_on, // ca
  input wire logic o_ck_term_on, // ck
  input wire logic o_cs_term_on, // cs
  input wire logic [15:0] o_dq_term_on, // dq
  input wire logic [1:0] o_dmi_term_on, // dmi
  input wire logic [1:0] o_dqs_term_on // dqs
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] idle;
  // readback shows live fields when the write set point equals the active set point
  wire act = i_fsp_wr == i_active_freq_set_point;
  wire dq_ok = act && o_cfg_rd[2:0] != 3'h0;
  wire blk = i_power_down || i_self_refresh;
  function automatic logic [7:0] ohm(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 8'h00 : 8'hF0 / {5'h00, c};
  endfunction
  // cycles since last write command
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || i_wr_first) begin
      idle <= 8'h00;
    end else if (idle != 8'hFF) begin
      idle <= idle + 8'h01;
    end
  end
  chk_rst_off: assert property (disable iff (1'b0) !i_rst_b |=> !o_ca_term_on && o_dq_term_on == 16'h0000)
    else $error("reset left termination on");
  chk_ca_ohm: assert property ((act && $stable(o_cfg_rd))[*3] |-> o_ca_ohm == ohm(o_cfg_rd[6:4]))
    else $error("ca ohms wrong");
  chk_dq_ohm: assert property ((act && $stable(o_cfg_rd))[*3] |-> o_dq_ohm == ohm(o_cfg_rd[2:0]))
    else $error("dq ohms wrong");
  chk_ca_lines: assert property ((act && $stable(o_cfg_rd) && $stable(o_ovr_rd))[*3] |->
    {o_ca_term_on, o_ck_term_on, o_cs_term_on} ==
    ({3{ohm(o_cfg_rd[6:4]) != 8'h00}} & ~{o_ovr_rd[5], o_ovr_rd[3], o_ovr_rd[4]}))
    else $error("ca lines wrong");
  chk_dq_block: assert property (blk || i_wr_level |=> {o_dq_term_on, o_dmi_term_on} == 18'h00000)
    else $error("dq on while blocked");
  chk_lvl_dqs: assert property ((i_wr_level && dq_ok && !blk)[*3] |-> o_dqs_term_on == 2'h3)
    else $error("dqs off in leveling");
  chk_on_lat: assert property (i_wr_first && dq_ok && !blk && !i_wr_level && $stable({i_fsp_wr, i_active_freq_set_point})
    ##1 (dq_ok && !blk && !i_wr_level)[*6]
    |-> {o_dq_term_on, o_dmi_term_on, o_dqs_term_on} == 20'hFFFFF)
    else $error("dq not on after write");
  chk_off_lat: assert property (idle == {2'h0, ODTL_OFF} + 8'h0C |-> {o_dq_term_on, o_dmi_term_on} == 18'h00000)
    else $error("dq still on after burst");
endmodule
bind otc_term_ctrl otc_chk #(.ODTL_OFF(ODTL_OFF)) u_chk (.*);

// *** tb/otc_ctrl_model.sv ***
// controller model: mode-register writes and write commands
`timescale 1ns/1ps
module otc_ctrl_model (
  input wire logic i_mclk, // clock
  output logic o_mrw_cfg = 1'b0, // config write
  output logic o_mrw_ovr = 1'b0, // override write
  output logic [7:0] o_mrw_data = 8'hA5, // write data
  output logic o_wr_first = 1'b0, // write command
  output logic o_bl32 = 1'b0 // burst 32
);
  // one register write; released data shows its inverse
  task automatic mrw(input logic ovr, input logic [7:0] d);
    o_mrw_ovr = ovr;
    o_mrw_cfg = !ovr;
    o_mrw_data = d;
    @(posedge i_mclk);
    #2;
    o_mrw_ovr = 1'b0;
    o_mrw_cfg = 1'b0;
    o_mrw_data = ~d;
  endtask
  // first part of a write, burst flag held only with it
  task automatic wr(input logic b);
    o_wr_first = 1'b1;
    o_bl32 = b;
    @(posedge i_mclk);
    #2;
    o_wr_first = 1'b0;
    o_bl32 = !b;
  endtask
endmodule

// *** tb/tb_otc_term_ctrl.sv ***
// bench: model of both set-point copies against the block
`timescale 1ns/1ps
module tb_otc_term_ctrl;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_fsp_wr = 1'b0, i_active_freq_set_point = 1'b0, on;
  logic i_power_down = 1'b0, i_self_refresh = 1'b0, i_wr_level = 1'b0, i_mrw_cfg, i_mrw_ovr, i_wr_first, i_bl32;
  logic o_ca_term_on, o_ck_term_on, o_cs_term_on;
  logic [7:0] i_mrw_data, o_cfg_rd, o_ovr_rd, o_ca_ohm, o_dq_ohm, cfg [2], ovr [2];
  logic [2:0] fld [5] = '{3'h2, 3'h0, 3'h3, 3'h6, 3'h5};
  logic [15:0] o_dq_term_on;
  logic [1:0] o_dmi_term_on, o_dqs_term_on;
  logic [31:0] seed = 32'hE5E34F06;
  int fails = 0, check_count = 0;
  // default write latencies and the extra cycles of a 32-beat burst
  localparam int ON_LAT = 4;
  localparam int OFF_LAT = 20;
  localparam int BL32_ADD = 8;
  otc_term_ctrl i_dut (.*);
  otc_ctrl_model u_ctl (.i_mclk, .o_mrw_cfg(i_mrw_cfg), .o_mrw_ovr(i_mrw_ovr), .o_mrw_data(i_mrw_data),
    .o_wr_first(i_wr_first), .o_bl32(i_bl32));
  // clock, 25 ns
  always #12.5 i_mclk = ~i_mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ohm(input int c);
    return (c > 0 && c < 7) ? 8'(240 / c) : 8'h00;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog, run needs about 410 cycles
  initial begin
    #50us;
    fails++;
    summarize();
  end
  // main sequence
  initial begin
    cfg = '{8'h00, 8'h00};
    ovr = '{8'h00, 8'h00};
    step(16);
    i_rst_b = 1'b1;
    chk("ca_after_reset", {o_ca_term_on, o_ck_term_on, o_cs_term_on, o_ca_ohm}, 20'h0);
    for (int c = 0; c < 16; c++) begin
      seed = lfsr(seed);
      i_fsp_wr = seed[0];
      i_active_freq_set_point = seed[1];
      ovr[i_fsp_wr] = seed[15:8];
      cfg[i_fsp_wr] = {1'b0, 3'(c), 1'b0, 3'(7 - c)};
      u_ctl.mrw(1'b1, ovr[i_fsp_wr]);
      step(1);
      u_ctl.mrw(1'b0, cfg[i_fsp_wr]);
      step(3);
      on = ohm(cfg[i_active_freq_set_point][6:4]) != 8'h00;
      chk("cfg_rd", o_cfg_rd, cfg[i_fsp_wr]);
      chk("ovr_rd", o_ovr_rd, ovr[i_fsp_wr]);
      chk("ca_ohm", o_ca_ohm, ohm(cfg[i_active_freq_set_point][6:4]));
      chk("dq_ohm", o_dq_ohm, ohm(cfg[i_active_freq_set_point][2:0]));
      chk("ca_lines", {o_ca_term_on, o_ck_term_on, o_cs_term_on},
        {3{on}} & ~{ovr[i_active_freq_set_point][5], ovr[i_active_freq_set_point][3], ovr[i_active_freq_set_point][4]});
    end
    // set point 0 only: data window per field code, then power-down, self-refresh and leveling
    i_fsp_wr = 1'b0;
    i_active_freq_set_point = 1'b0;
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      cfg[0] = {5'h00, fld[k]};
      u_ctl.mrw(1'b0, cfg[0]);
      i_power_down = k == 2;
      i_self_refresh = k == 3;
      i_wr_level = k == 4;
      step(2);
      u_ctl.wr(seed[2]);
      step(6);
      on = fld[k] != 3'h0 && k < 2;
      chk("dq_on", {o_dq_term_on, o_dmi_term_on}, {18{on}});
      chk("dqs_on", o_dqs_term_on, {2{on || k == 4}});
      step(30);
      chk("dq_off", {o_dq_term_on, o_dmi_term_on}, 20'h0);
    end
    // exact window edges for both burst lengths
    i_wr_level = 1'b0;
    ovr[0] = 8'h00;
    cfg[0] = 8'h13;
    u_ctl.mrw(1'b1, ovr[0]);
    step(1);
    u_ctl.mrw(1'b0, cfg[0]);
    step(2);
    for (int b = 0; b < 2; b++) begin
      u_ctl.wr(b[0]);
      step(ON_LAT - 1);
      chk("on_early", o_dq_term_on, 20'h0);
      step(1);
      chk("on_edge", o_dq_term_on, 20'hFFFF);
      step(OFF_LAT + BL32_ADD * b - ON_LAT - 1);
      chk("off_late", o_dq_term_on, 20'hFFFF);
      step(1);
      chk("off_edge", o_dq_term_on, 20'h0);
      step(4);
    end
    // a second write inside the window moves the off point
    u_ctl.wr(1'b0);
    step(7);
    u_ctl.wr(1'b0);
    step(OFF_LAT - 1);
    chk("extend_late", {o_dqs_term_on, o_dmi_term_on}, 20'hF);
    step(1);
    chk("extend_edge", {o_dqs_term_on, o_dmi_term_on}, 20'h0);
    // second reset in the middle of an open window
    u_ctl.wr(1'b0);
    step(6);
    chk("pre_rst", {o_ca_term_on, o_ck_term_on, o_cs_term_on, o_dq_term_on}, {3'h7, 16'hFFFF});
    i_rst_b = 1'b0;
    step(2);
    i_rst_b = 1'b1;
    cfg = '{8'h00, 8'h00};
    ovr = '{8'h00, 8'h00};
    chk("rst_dq", {o_dq_term_on, o_dmi_term_on, o_dqs_term_on}, 20'h0);
    chk("rst_ca", {o_ca_term_on, o_ck_term_on, o_cs_term_on, o_ca_ohm}, 20'h0);
    chk("rst_rd", {o_cfg_rd, o_ovr_rd}, {cfg[0], ovr[0]});
    summarize();
  end
endmodule
